//--- rtl/cpu_exec_pkg.sv
// constants, types and arithmetic helpers of the execution unit
// assumes one core clock and a decoder that fills op_req_t
package cpu_exec_pkg;

	localparam int CLK_PERIOD_NS = 10;

	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] ALL_ZERO = 8'h00;
	localparam logic [4:0] PTR_LO_IDX = 5'h1e;
	localparam logic [4:0] PTR_HI_IDX = 5'h1f;
	localparam logic [5:0] IO_BIT_MAX = 6'h1f;

	// cycle counts
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_JUMP = 3'h2;
	localparam logic [2:0] CYC_CALL = 3'h3;
	localparam logic [2:0] CYC_RET = 3'h4;
	localparam logic [2:0] CYC_IO_BIT = 3'h2;
	localparam logic [2:0] CYC_TAKEN = 3'h2;
	localparam logic [2:0] CYC_SKIP1 = 3'h2;
	localparam logic [2:0] CYC_SKIP2 = 3'h3;

	// use_imm turns the register forms into their constant forms
	typedef enum logic [5:0] {
		add_plain, add_carry, minus, minus_with_borrow, word_immediate_sum, word_immediate_minus,
		conjunction, disjunction, exclusive_disjunction, mask_bits_low, bit_invert, arith_inverse,
		increment, decrement, zero_sign_check, zero_fill, all_ones_fill, compare, compare_borrow,
		equal_skip, skip_reg_bit_low, skip_reg_bit_high, io_skip_low, io_skip_high,
		relative_jump, pointer_jump, relative_subroutine_entry, pointer_subroutine_entry,
		routine_exit, irq_exit, flag_high_branch, flag_low_branch, signed_ge_branch,
		signed_lt_branch, io_bit_high, io_bit_low, shift_up, shift_down, rotate_up_carry,
		rotate_down_carry
	} op_t;

	typedef struct packed {
		op_t code;
		logic use_imm;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [7:0] imm;
		logic [2:0] sel;
		logic [11:0] offset;
		logic [5:0] io_addr;
	} op_req_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic h;
		logic v;
	} alu_t;

	typedef struct packed {
		logic we;
		logic [5:0] addr;
		logic [2:0] sel;
		logic val;
	} io_bit_wr_t;

	typedef struct packed {
		logic push;
		logic pop;
		logic [15:0] wdata;
	} stack_req_t;

	function automatic alu_t add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		alu_t r;
		logic [8:0] s;
		logic [4:0] l;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r.res = s[7:0];
		r.c = s[8];
		r.h = l[4];
		r.v = (a[7] == b[7]) && (s[7] != a[7]);
		return r;
	endfunction

	function automatic alu_t sub8(input logic [7:0] a, input logic [7:0] b, input logic bin);
		alu_t r;
		logic [8:0] s;
		logic [4:0] l;
		s = {1'b0, a} - {1'b0, b} - {8'h00, bin};
		l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
		r.res = s[7:0];
		r.c = s[8];
		r.h = l[4];
		r.v = (a[7] != b[7]) && (s[7] != a[7]);
		return r;
	endfunction

	function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [11:0] k);
		return pc + {{4{k[11]}}, k} + 16'h0001;
	endfunction

endpackage

//--- rtl/work_reg_file.sv
// 32 x 8 working registers, two registered read ports, one write port
// assumes reads are issued one cycle before the data is used
`timescale 1ns/1ps
module work_reg_file (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] raddr_a,
	input wire logic [4:0] raddr_b,
	output logic [7:0] rdata_a,
	output logic [7:0] rdata_b,
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [7:0] wdata
);
	logic [7:0] mem [0:31];

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_a <= 8'h00;
			rdata_b <= 8'h00;
		end else begin
			rdata_a <= mem[raddr_a];
			rdata_b <= mem[raddr_b];
		end
	end
endmodule

//--- rtl/cpu_alu_branch_exec.sv
// execution unit: arithmetic, logic, shifts, flags, jumps, calls, skips, branches, io bit ops
// assumes a decoder upstream, a stack and an io space outside answering in the same cycle
`timescale 1ns/1ps
module cpu_alu_branch_exec (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	output logic op_ready,
	input wire cpu_exec_pkg::op_req_t op_req,
	output logic op_done,
	input wire logic next_two_word,
	output logic [15:0] prog_counter,
	output logic [7:0] status_flags,
	output cpu_exec_pkg::io_bit_wr_t io_bus,
	input wire logic [7:0] io_rdata,
	output logic io_fault,
	output cpu_exec_pkg::stack_req_t stack_req,
	input wire logic [15:0] stack_rdata
);
	import cpu_exec_pkg::*;

	typedef enum {st_idle, st_exec, st_stall} state_t;

	state_t st_q, st_d;
	op_req_t op_q, op_d;
	logic [2:0] cnt_q, cnt_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0] flags_q, flags_d;
	logic [7:0] hi_q, hi_d;
	logic hi_pend_q, hi_pend_d;
	io_bit_wr_t io_q, io_d;
	stack_req_t stk_q, stk_d;
	logic fault_q, fault_d;
	logic [4:0] raddr_a, raddr_b;
	logic [7:0] rdata_a, rdata_b;
	logic rf_we;
	logic [4:0] rf_waddr;
	logic [7:0] rf_wdata;
	logic [7:0] opb;
	logic [2:0] cyc;
	alu_t r;
	logic [7:0] fmask;
	logic [7:0] newf;
	logic [16:0] wsum;
	logic take;
	logic io_ok;
	logic accept;

	work_reg_file u_regs (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.raddr_a(raddr_a),
		.raddr_b(raddr_b),
		.rdata_a(rdata_a),
		.rdata_b(rdata_b),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(rf_wdata)
	);

	assign op_ready = (st_q == st_idle);
	assign accept = op_valid && op_ready;
	assign op_done = (st_q == st_exec && cyc == CYC_ONE) || (st_q == st_stall && cnt_q == 3'h1);
	assign prog_counter = pc_q;
	assign status_flags = flags_q;
	assign io_bus = io_q;
	assign stack_req = stk_q;
	assign io_fault = fault_q;
	assign opb = op_q.use_imm ? op_q.imm : rdata_b;
	assign io_ok = (op_q.io_addr <= IO_BIT_MAX);

	// operand read addresses are taken from the request in the accept cycle
	always_comb begin
		raddr_a = op_req.rd;
		raddr_b = op_req.rr;
		if (op_req.code == word_immediate_sum || op_req.code == word_immediate_minus) begin
			raddr_b = op_req.rd + 5'h01;
		end else if (op_req.code == pointer_jump || op_req.code == pointer_subroutine_entry) begin
			raddr_a = PTR_LO_IDX;
			raddr_b = PTR_HI_IDX;
		end
	end

	// datapath result and which flags it owns
	always_comb begin
		r = '{res: rdata_a, c: 1'b0, h: 1'b0, v: 1'b0};
		fmask = 8'h00;
		wsum = 17'h00000;
		case (op_q.code)
			add_plain, add_carry: begin
				r = add8(rdata_a, opb, op_q.code == add_carry && flags_q[FLAG_C]);
				fmask = 8'h2f;
			end
			minus, minus_with_borrow: begin
				r = sub8(rdata_a, opb, op_q.code == minus_with_borrow && flags_q[FLAG_C]);
				fmask = 8'h2f;
			end
			compare, compare_borrow: begin
				r = sub8(rdata_a, opb, op_q.code == compare_borrow && flags_q[FLAG_C]);
				fmask = 8'h2f;
			end
			word_immediate_sum, word_immediate_minus: begin
				if (op_q.code == word_immediate_sum) begin
					wsum = {1'b0, rdata_b, rdata_a} + {11'h000, op_q.imm[5:0]};
					r.v = !rdata_b[7] && wsum[15];
				end else begin
					wsum = {1'b0, rdata_b, rdata_a} - {11'h000, op_q.imm[5:0]};
					r.v = rdata_b[7] && !wsum[15];
				end
				r.res = wsum[7:0];
				r.c = wsum[16];
				fmask = 8'h1f;
			end
			conjunction: begin
				r.res = rdata_a & opb;
				fmask = 8'h0e;
			end
			disjunction: begin
				r.res = rdata_a | opb;
				fmask = 8'h0e;
			end
			exclusive_disjunction: begin
				r.res = rdata_a ^ opb;
				fmask = 8'h0e;
			end
			mask_bits_low: begin
				r.res = rdata_a & (ALL_ONES - op_q.imm);
				fmask = 8'h0e;
			end
			bit_invert: begin
				r.res = ALL_ONES - rdata_a;
				r.c = 1'b1;
				fmask = 8'h0f;
			end
			arith_inverse: begin
				r = sub8(ALL_ZERO, rdata_a, 1'b0);
				fmask = 8'h2f;
			end
			increment: begin
				r.res = rdata_a + 8'h01;
				r.v = (rdata_a == 8'h7f);
				fmask = 8'h0e;
			end
			decrement: begin
				r.res = rdata_a - 8'h01;
				r.v = (rdata_a == 8'h80);
				fmask = 8'h0e;
			end
			zero_sign_check: fmask = 8'h0e;
			zero_fill: begin
				r.res = ALL_ZERO;
				fmask = 8'h0e;
			end
			all_ones_fill: r.res = ALL_ONES;
			shift_up, rotate_up_carry: begin
				r.res = {rdata_a[6:0], op_q.code == rotate_up_carry && flags_q[FLAG_C]};
				r.c = rdata_a[7];
				r.v = r.res[7] ^ r.c;
				fmask = 8'h0f;
			end
			shift_down, rotate_down_carry: begin
				r.res = {op_q.code == rotate_down_carry && flags_q[FLAG_C], rdata_a[7:1]};
				r.c = rdata_a[0];
				r.v = r.res[7] ^ r.c;
				fmask = 8'h0f;
			end
			default: fmask = 8'h00;
		endcase
		newf = 8'h00;
		newf[FLAG_C] = r.c;
		newf[FLAG_Z] = (op_q.code == word_immediate_sum || op_q.code == word_immediate_minus) ?
			(wsum[15:0] == 16'h0000) : (r.res == ALL_ZERO);
		newf[FLAG_N] = (op_q.code == word_immediate_sum || op_q.code == word_immediate_minus) ?
			wsum[15] : r.res[7];
		newf[FLAG_V] = r.v;
		newf[FLAG_S] = newf[FLAG_N] ^ r.v;
		newf[FLAG_H] = r.h;
	end

	// control flow decision and cycle count
	always_comb begin
		take = 1'b0;
		cyc = CYC_ONE;
		case (op_q.code)
			word_immediate_sum, word_immediate_minus: cyc = CYC_WORD;
			relative_jump, pointer_jump: cyc = CYC_JUMP;
			relative_subroutine_entry, pointer_subroutine_entry: cyc = CYC_CALL;
			routine_exit, irq_exit: cyc = CYC_RET;
			io_bit_high, io_bit_low: cyc = CYC_IO_BIT;
			equal_skip: take = (rdata_a == rdata_b);
			skip_reg_bit_low: take = !rdata_b[op_q.sel];
			skip_reg_bit_high: take = rdata_b[op_q.sel];
			io_skip_low: take = io_ok && !io_rdata[op_q.sel];
			io_skip_high: take = io_ok && io_rdata[op_q.sel];
			flag_high_branch: take = flags_q[op_q.sel];
			flag_low_branch: take = !flags_q[op_q.sel];
			signed_ge_branch: take = !(flags_q[FLAG_N] ^ flags_q[FLAG_V]);
			signed_lt_branch: take = flags_q[FLAG_N] ^ flags_q[FLAG_V];
			default: take = 1'b0;
		endcase
		if (take) begin
			if (op_q.code == flag_high_branch || op_q.code == flag_low_branch ||
				op_q.code == signed_ge_branch || op_q.code == signed_lt_branch) begin
				cyc = CYC_TAKEN;
			end else begin
				cyc = next_two_word ? CYC_SKIP2 : CYC_SKIP1;
			end
		end
	end

	// sequencing, register write back, pc and side effects
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		cnt_d = cnt_q;
		pc_d = pc_q;
		flags_d = flags_q;
		hi_d = hi_q;
		hi_pend_d = 1'b0;
		io_d = io_q;
		io_d.we = 1'b0;
		stk_d = stk_q;
		stk_d.push = 1'b0;
		stk_d.pop = 1'b0;
		fault_d = 1'b0;
		rf_we = 1'b0;
		rf_waddr = op_q.rd;
		rf_wdata = r.res;
		case (st_q)
			st_idle: begin
				if (accept) begin
					op_d = op_req;
					io_d.addr = op_req.io_addr;
					st_d = st_exec;
				end
			end
			st_exec: begin
				flags_d = (flags_q & ~fmask) | (newf & fmask);
				rf_we = (fmask != 8'h00 || op_q.code == all_ones_fill) &&
					op_q.code != compare && op_q.code != compare_borrow;
				pc_d = pc_q + {13'h0000, cyc};
				case (op_q.code)
					word_immediate_sum, word_immediate_minus: begin
						hi_d = wsum[15:8];
						hi_pend_d = 1'b1;
					end
					relative_jump: pc_d = rel_target(pc_q, op_q.offset);
					pointer_jump: pc_d = {rdata_b, rdata_a};
					relative_subroutine_entry, pointer_subroutine_entry: begin
						pc_d = (op_q.code == pointer_subroutine_entry) ? {rdata_b, rdata_a} :
							rel_target(pc_q, op_q.offset);
						stk_d.push = 1'b1;
						stk_d.wdata = pc_q + 16'h0001;
					end
					routine_exit, irq_exit: begin
						stk_d.pop = 1'b1;
						flags_d[FLAG_I] = flags_q[FLAG_I] || (op_q.code == irq_exit);
					end
					flag_high_branch, flag_low_branch, signed_ge_branch, signed_lt_branch: begin
						pc_d = take ? rel_target(pc_q, op_q.offset) : pc_q + 16'h0001;
					end
					io_bit_high, io_bit_low: begin
						io_d.we = io_ok;
						io_d.sel = op_q.sel;
						io_d.val = (op_q.code == io_bit_high);
						fault_d = !io_ok;
						pc_d = pc_q + 16'h0001;
					end
					io_skip_low, io_skip_high: fault_d = !io_ok;
					default: begin
					end
				endcase
				if (cyc == CYC_ONE) begin
					st_d = st_idle;
				end else begin
					cnt_d = cyc - 3'h1;
					st_d = st_stall;
				end
			end
			st_stall: begin
				if (hi_pend_q) begin
					rf_we = 1'b1;
					rf_waddr = op_q.rd + 5'h01;
					rf_wdata = hi_q;
				end
				if (stk_q.pop) begin
					pc_d = stack_rdata;
				end
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1) begin
					st_d = st_idle;
				end
			end
			default: st_d = st_idle;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= st_idle;
			op_q <= '0;
			cnt_q <= 3'h0;
			pc_q <= PC_RESET;
			flags_q <= FLAGS_RESET;
			hi_q <= 8'h00;
			hi_pend_q <= 1'b0;
			io_q <= '0;
			stk_q <= '0;
			fault_q <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			cnt_q <= cnt_d;
			pc_q <= pc_d;
			flags_q <= flags_d;
			hi_q <= hi_d;
			hi_pend_q <= hi_pend_d;
			io_q <= io_d;
			stk_q <= stk_d;
			fault_q <= fault_d;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_ADD_SUM: assert property (
		st_q == st_exec && op_q.code == add_plain && !op_q.use_imm |->
		rf_we && rf_wdata == 8'(rdata_a + rdata_b) && op_done)
		else $error("add result or timing wrong");

	AST_WORD_HIGH: assert property (
		st_q == st_exec && op_q.code == word_immediate_sum |->
		!op_done ##1 (op_done && rf_we && rf_waddr == 5'(op_q.rd + 5'h01)))
		else $error("word add high byte not written in second cycle");

	AST_LOGIC_CARRY: assert property (
		st_q == st_exec && (op_q.code == conjunction || op_q.code == exclusive_disjunction) |=>
		flags_q[FLAG_C] == $past(flags_q[FLAG_C]) && flags_q[FLAG_H] == $past(flags_q[FLAG_H]))
		else $error("logic op changed carry or half carry");

	AST_SET_ALL: assert property (
		st_q == st_exec && op_q.code == all_ones_fill |-> rf_wdata == ALL_ONES ##1 $stable(flags_q))
		else $error("set register wrong or flags moved");

	AST_CMP_NOWRITE: assert property (
		st_q == st_exec && (op_q.code == compare || op_q.code == compare_borrow) |-> !rf_we && op_done)
		else $error("compare wrote a register");

	AST_RELATIVE_JUMP: assert property (
		st_q == st_exec && op_q.code == relative_jump |=>
		pc_q == 16'($past(pc_q) + {{4{$past(op_q.offset[11])}}, $past(op_q.offset)} + 16'h0001) && op_done)
		else $error("relative jump target or timing wrong");

	AST_CALL_CYCLES: assert property (
		accept && op_req.code == relative_subroutine_entry |->
		##1 (!op_done && stk_d.push) ##1 !op_done ##1 op_done)
		else $error("call did not take three cycles");

	AST_IRQ_EXIT_I: assert property (
		st_q == st_exec && op_q.code == irq_exit |=> flags_q[FLAG_I] && stk_q.pop)
		else $error("interrupt return did not set I");

	AST_IO_RANGE: assert property (
		io_q.we |-> io_q.addr <= IO_BIT_MAX && $past(st_q) == st_exec)
		else $error("io bit written outside bit range");

	AST_BR_NOT_TAKEN: assert property (
		st_q == st_exec && op_q.code == flag_high_branch && !flags_q[op_q.sel] |->
		op_done ##1 pc_q == 16'($past(pc_q) + 16'h0001))
		else $error("untaken branch wrong");

endmodule

//--- verif/tb.sv
// self-checking bench for the execution unit: alu rows, word ops, control flow, io bits
// assumes the design package and the unit's hand-over timing; bench plays decoder, io space and stack
`timescale 1ns/1ps
module tb;
	import cpu_exec_pkg::*;
	typedef struct packed {
		op_t c;
		logic [1:0] ic;
		logic [39:0] v;
	} row_t;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic op_valid = 1'h0;
	logic op_ready, op_done, io_fault, tk;
	op_req_t op_req = '0;
	logic next_two_word = 1'h0;
	logic [15:0] prog_counter, psh_d, ep;
	logic [7:0] status_flags, f0, ef;
	io_bit_wr_t io_bus, io_seen;
	logic [7:0] io_rdata = 8'h00;
	stack_req_t stack_req;
	logic [15:0] stack_rdata = 16'h0abc;
	int fails = 0, checks_done = 0, n, i, j, we_n = 0, flt_n = 0, psh_n = 0, pop_n = 0;
	row_t rows[25];
	logic [4:0] sr[3];
	logic [7:0] sk[3], sf[3];

	always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

	cpu_alu_branch_exec cpu_alu_branch_exec_i (.sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid),
		.op_ready(op_ready), .op_req(op_req), .op_done(op_done), .next_two_word(next_two_word),
		.prog_counter(prog_counter), .status_flags(status_flags), .io_bus(io_bus), .io_rdata(io_rdata),
		.io_fault(io_fault), .stack_req(stack_req), .stack_rdata(stack_rdata));

	// pulse capture of io and stack traffic
	always @(negedge sys_clk) begin
		if (io_bus.we === 1'h1) begin
			we_n++;
			io_seen = io_bus;
		end
		if (io_fault === 1'h1)
			flt_n++;
		if (stack_req.push === 1'h1) begin
			psh_n++;
			psh_d = stack_req.wdata;
		end
		if (stack_req.pop === 1'h1)
			pop_n++;
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic op_req_t q(op_t c, logic [4:0] d = 5'h10, logic [7:0] k = 8'h00, logic [2:0] s = 3'h0,
		logic [11:0] o = 12'h000, logic [5:0] a = 6'h00, logic im = 1'h0, logic [4:0] r = 5'h11);
		q = '{c, im, d, r, k, s, o, a};
	endfunction

	// called at a falling edge with the unit idle
	task automatic run(input op_req_t r, input logic [15:0] np, input int c);
		op_req = r;
		op_valid = 1'h1;
		@(negedge sys_clk);
		op_valid = 1'h0;
		n = 1;
		while (op_done !== 1'h1 && n < 9) begin
			@(negedge sys_clk);
			n++;
		end
		if (n > 8) begin
			$display("[ERR] %0t op never completed", $time);
			fails++;
			end_of_test;
		end
		@(negedge sys_clk);
		chk(prog_counter, np);
		if (c != 0)
			chk(16'(n), 16'(c));
		ep = np;
	endtask

	task automatic ex(input op_req_t r);
		run(r, ep + 16'h0001, 1);
	endtask

	task automatic setr(input logic [4:0] d, input logic [7:0] v);
		ex(q(zero_fill, d));
		ex(q(minus, d, 8'h00 - v, 3'h0, 12'h000, 6'h00, 1'h1));
	endtask

	task automatic chkr(input logic [4:0] d, input logic [7:0] v);
		ex(q(compare, d, v, 3'h0, 12'h000, 6'h00, 1'h1));
		chk({15'h0000, status_flags[FLAG_Z]}, 16'h0001);
	endtask

	task automatic rchk;
		chk({14'h0000, op_ready, op_done}, 16'h0002);
		chk(prog_counter, PC_RESET);
		chk({8'h00, status_flags}, {8'h00, FLAGS_RESET});
		chk({4'h0, io_bus, io_fault}, 16'h0000);
		chk({14'h0000, stack_req.push, stack_req.pop}, 16'h0000);
	endtask

	initial begin
		// a, b, result, flag mask, flags; ic is {constant form, carry in}
		rows = '{'{add_plain, 2'h0, 40'h0f01102f20}, '{add_carry, 2'h1, 40'h7f00802f2c},
			'{minus, 2'h0, 40'h10010f2f20}, '{minus, 2'h2, 40'h0505002f02},
			'{minus_with_borrow, 2'h1, 40'h0000ff2f25}, '{minus_with_borrow, 2'h3, 40'h80007f2f28},
			'{conjunction, 2'h1, 40'hf08f800e04}, '{conjunction, 2'h3, 40'h0ff0000e02},
			'{disjunction, 2'h3, 40'h1081910e04}, '{exclusive_disjunction, 2'h1, 40'hffff000e02},
			'{mask_bits_low, 2'h3, 40'hff0ff00e04}, '{bit_invert, 2'h0, 40'h0000ff0f05},
			'{arith_inverse, 2'h0, 40'h0100ff2f25}, '{increment, 2'h1, 40'h7f00800e0c},
			'{decrement, 2'h1, 40'h0000ff0e04}, '{zero_sign_check, 2'h0, 40'h8000800e04},
			'{zero_fill, 2'h1, 40'h5500000e02}, '{all_ones_fill, 2'h1, 40'h1200ff0000},
			'{compare, 2'h0, 40'h0102012f25}, '{compare_borrow, 2'h1, 40'h0201022f02},
			'{compare, 2'h2, 40'h8001802f28}, '{shift_up, 2'h0, 40'h8100020f09},
			'{rotate_up_carry, 2'h1, 40'h4000810f0c}, '{shift_down, 2'h0, 40'h0100000f0b},
			'{rotate_down_carry, 2'h1, 40'h0200810f0c}};
		sr = '{5'h14, 5'h14, 5'h15};
		sk = '{8'h00, 8'h01, 8'h01};
		sf = '{8'h82, 8'ha5, 8'ha8};
		ep = PC_RESET;
		repeat (16) @(negedge sys_clk);
		rchk;
		rst_n = 1'h1;
		@(negedge sys_clk);
		$display("test reset done");
		for (i = 0; i < 25; i++) begin
			setr(5'h10, rows[i].v[39:32]);
			setr(5'h11, rows[i].v[31:24]);
			setr(5'h14, 8'h00);
			ex(q(compare, 5'h14, {7'h00, rows[i].ic[0]}, 3'h0, 12'h000, 6'h00, 1'h1));
			f0 = status_flags;
			ex(q(rows[i].c, 5'h10, rows[i].v[31:24], 3'h0, 12'h000, 6'h00, rows[i].ic[1]));
			ef = (f0 & ~rows[i].v[15:8]) | (rows[i].v[7:0] & rows[i].v[15:8]);
			chk({8'h00, status_flags}, {8'h00, ef});
			chkr(5'h10, rows[i].v[23:16]);
		end
		$display("test alu rows done");
		setr(5'h18, 8'hff);
		setr(5'h19, 8'h00);
		f0 = status_flags;
		run(q(word_immediate_sum, 5'h18, 8'h01, 3'h0, 12'h000, 6'h00, 1'h1), ep + 16'h0002, 2);
		chk({8'h00, status_flags}, {8'h00, f0 & 8'he0});
		chkr(5'h18, 8'h00);
		chkr(5'h19, 8'h01);
		setr(5'h19, 8'h00);
		f0 = status_flags;
		run(q(word_immediate_minus, 5'h18, 8'h01, 3'h0, 12'h000, 6'h00, 1'h1), ep + 16'h0002, 2);
		chk({8'h00, status_flags}, {8'h00, (f0 & 8'he0) | 8'h15});
		chkr(5'h19, 8'hff);
		$display("test word ops done");
		setr(5'h1e, 8'h34);
		setr(5'h1f, 8'h12);
		f0 = status_flags;
		run(q(relative_jump, 5'h10, 8'h00, 3'h0, 12'hffe), ep - 16'h0001, 2);
		run(q(pointer_jump), 16'h1234, 2);
		run(q(relative_subroutine_entry, 5'h10, 8'h00, 3'h0, 12'h010), 16'h1245, 3);
		chk(psh_d, 16'h1235);
		run(q(pointer_subroutine_entry), 16'h1234, 3);
		chk(psh_d, 16'h1246);
		chk(16'(psh_n), 16'h0002);
		run(q(routine_exit), 16'h0abc, 4);
		chk({8'h00, status_flags}, {8'h00, f0});
		stack_rdata = 16'h0def;
		run(q(irq_exit), 16'h0def, 4);
		chk({8'h00, status_flags}, {8'h00, f0 | 8'h80});
		chk(16'(pop_n), 16'h0002);
		$display("test jumps and calls done");
		setr(5'h15, 8'h80);
		for (i = 0; i < 3; i++) begin
			for (j = 0; j < 18; j++) begin
				if (j % 8 == 4)
					continue;
				ex(q(compare, sr[i], sk[i], 3'h0, 12'h000, 6'h00, 1'h1));
				tk = j < 16 ? (sf[i][j % 8] == (j < 8)) : ((sf[i][2] ^ sf[i][3]) == (j == 17));
				run(q(j < 8 ? flag_high_branch : j < 16 ? flag_low_branch : j == 16 ? signed_ge_branch :
					signed_lt_branch, 5'h10, 8'h00, 3'(j % 8), 12'h005), tk ? ep + 16'h0006 : ep + 16'h0001,
					tk ? 2 : 1);
			end
		end
		$display("test branches done");
		setr(5'h10, 8'h80);
		setr(5'h11, 8'h80);
		run(q(equal_skip), ep + 16'h0002, 2);
		next_two_word = 1'h1;
		run(q(equal_skip), ep + 16'h0003, 3);
		run(q(skip_reg_bit_high, 5'h10, 8'h00, 3'h7, 12'h000, 6'h00, 1'h0, 5'h10), ep + 16'h0003, 3);
		run(q(skip_reg_bit_low, 5'h10, 8'h00, 3'h7, 12'h000, 6'h00, 1'h0, 5'h10), ep + 16'h0001, 1);
		next_two_word = 1'h0;
		run(q(skip_reg_bit_low, 5'h10, 8'h00, 3'h0, 12'h000, 6'h00, 1'h0, 5'h10), ep + 16'h0002, 2);
		run(q(equal_skip, 5'h10, 8'h00, 3'h0, 12'h000, 6'h00, 1'h0, 5'h14), ep + 16'h0001, 1);
		io_rdata = 8'h04;
		run(q(io_skip_high, 5'h10, 8'h00, 3'h2, 12'h000, 6'h05), ep + 16'h0002, 2);
		run(q(io_skip_low, 5'h10, 8'h00, 3'h2, 12'h000, 6'h05), ep + 16'h0001, 1);
		io_rdata = 8'hfb;
		next_two_word = 1'h1;
		run(q(io_skip_low, 5'h10, 8'h00, 3'h2, 12'h000, 6'h1f), ep + 16'h0003, 3);
		run(q(io_skip_high, 5'h10, 8'h00, 3'h2, 12'h000, 6'h20), ep + 16'h0001, 1);
		next_two_word = 1'h0;
		$display("test skips done");
		f0 = status_flags;
		run(q(io_bit_high, 5'h10, 8'h00, 3'h3, 12'h000, 6'h1f), ep + 16'h0001, 2);
		chk(16'(flt_n), 16'h0001);
		chk({6'h00, io_seen.addr, io_seen.sel, io_seen.val}, {6'h00, 6'h1f, 3'h3, 1'h1});
		run(q(io_bit_low, 5'h10, 8'h00, 3'h0, 12'h000, 6'h00), ep + 16'h0001, 2);
		chk({6'h00, io_seen.addr, io_seen.sel, io_seen.val}, {6'h00, 6'h00, 3'h0, 1'h0});
		run(q(io_bit_high, 5'h10, 8'h00, 3'h5, 12'h000, 6'h20), ep + 16'h0001, 2);
		chk(16'(we_n), 16'h0002);
		chk(16'(flt_n), 16'h0002);
		chk({8'h00, status_flags}, {8'h00, f0});
		$display("test io bits done");
		// reset in the middle of a return
		op_req = q(routine_exit);
		op_valid = 1'h1;
		@(negedge sys_clk);
		op_valid = 1'h0;
		@(negedge sys_clk);
		rst_n = 1'h0;
		@(negedge sys_clk);
		rchk;
		rst_n = 1'h1;
		ep = PC_RESET;
		@(negedge sys_clk);
		ex(q(zero_fill));
		$display("test mid reset done");
		end_of_test;
	end
endmodule
